// [grpd_gpio.sv]
// Pin block with its faulty reset defaults on ports A, B, D and F
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Reset sets alt select on A5:0, B3:2
// - Alt defaults drive UART tx/fss high, sync clock/tx low
// - Two-wire clock holds level one osc clock
// - D7 and F0 function codes reset 0x3
// - Code 0x3 on F0 feeds CAN receive
// - High on D7/F0 in reset function: NMI
// - B1 may stay high after warm reset
module grpd_gpio (
    input  wire logic                    clk_i,
    input  wire logic                    rst_b_i,
    input  wire logic                    por_i,
    input  wire logic                    osc_tick_i,
    input  wire logic                    two_wire_mode_i,
    input  wire logic                    two_wire_clk_out_i,
    input  wire logic                    wr_en_i,
    input  wire logic [1:0]              wr_port_i,
    input  wire grpd_pkg::grpd_port_cfg_t wr_cfg_i,
    input  wire logic                    commit_d7_i,
    input  wire logic                    commit_f0_i,
    input  wire logic                    fcode_wr_i,
    input  wire logic [3:0]              fcode_d7_i,
    input  wire logic [3:0]              fcode_f0_i,
    input  wire logic [7:0]              pin_d_i,
    input  wire logic [7:0]              pin_f_i,
    output grpd_pkg::grpd_pin_drv_t      drv_a_o,
    output grpd_pkg::grpd_pin_drv_t      drv_b_o,
    output grpd_pkg::grpd_pin_drv_t      drv_d_o,
    output grpd_pkg::grpd_pin_drv_t      drv_f_o,
    output logic [7:0]                   alt_a_o,
    output logic [7:0]                   alt_b_o,
    output logic [7:0]                   alt_d_o,
    output logic [7:0]                   alt_f_o,
    output logic [3:0]                   fcode_d7_o,
    output logic [3:0]                   fcode_f0_o,
    output logic                         can_receive_line_o,
    output logic                         nmi_o
);
    grpd_pkg::grpd_port_cfg_t cfg_a, cfg_b, cfg_d, cfg_f;
    grpd_pkg::grpd_port_cfg_t next_a, next_b, next_d, next_f;
    logic [3:0] fc_d7, fc_f0, next_fc_d7, next_fc_f0;
    logic       armed, next_armed, ret_lvl, next_ret_lvl;
    logic       ret_b1, next_ret_b1, b1_stuck, next_b1_stuck;
    logic       warm, next_warm, pon, hold_drv, b1_drv;
    logic [7:0] sd, sf;

    // Board inputs pass the three-stage synchroniser
    grpd_sync3 #(.W(8)) u_sync_d (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (pin_d_i),
        .q_o     (sd)
    );
    grpd_sync3 #(.W(8)) u_sync_f (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (pin_f_i),
        .q_o     (sf)
    );

    // Software writes; protected bits need their commit enable
    always_comb begin
        next_a = cfg_a;
        next_b = cfg_b;
        next_d = cfg_d;
        next_f = cfg_f;
        next_fc_d7 = fc_d7;
        next_fc_f0 = fc_f0;
        if (wr_en_i) begin
            unique case (wr_port_i)
                2'h0: next_a = wr_cfg_i;
                2'h1: next_b = wr_cfg_i;
                2'h2: begin
                    next_d = wr_cfg_i;
                    if (!commit_d7_i) begin
                        next_d.alt_sel[grpd_pkg::PD_LINE_SEVEN] =
                            cfg_d.alt_sel[grpd_pkg::PD_LINE_SEVEN];
                    end
                end
                2'h3: begin
                    next_f = wr_cfg_i;
                    if (!commit_f0_i) begin
                        next_f.alt_sel[grpd_pkg::PF_LINE_ZERO] =
                            cfg_f.alt_sel[grpd_pkg::PF_LINE_ZERO];
                    end
                end
            endcase
        end
        if (fcode_wr_i && commit_d7_i) begin
            next_fc_d7 = fcode_d7_i;
        end
        if (fcode_wr_i && commit_f0_i) begin
            next_fc_f0 = fcode_f0_i;
        end
    end

    // Configuration state; every reset forces the faulty defaults
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_a <= {grpd_pkg::ALT_SEL_A_RESET, grpd_pkg::DEN_RESET,
                      8'h00, 8'h00};
            cfg_b <= {grpd_pkg::ALT_SEL_B_RESET, grpd_pkg::DEN_RESET,
                      8'h00, 8'h00};
            cfg_d <= {grpd_pkg::ALT_SEL_D_RESET, grpd_pkg::DEN_RESET,
                      8'h00, 8'h00};
            cfg_f <= {grpd_pkg::ALT_SEL_F_RESET, grpd_pkg::DEN_RESET,
                      8'h00, 8'h00};
            fc_d7 <= grpd_pkg::FCODE_RESET;
            fc_f0 <= grpd_pkg::FCODE_RESET;
        end else begin
            cfg_a <= next_a;
            cfg_b <= next_b;
            cfg_d <= next_d;
            cfg_f <= next_f;
            fc_d7 <= next_fc_d7;
            fc_f0 <= next_fc_f0;
        end
    end

    // Power-on reset in progress wipes the retained state
    assign pon = por_i && !warm;
    // Drive through reset comes from state that reset does not clear
    assign hold_drv = !pon && !warm && armed;
    assign b1_drv   = !pon && (b1_stuck || (!warm && ret_b1));

    // Retained state tracks the pins while running; in reset the levels freeze, b1_stuck loads ret_b1 and armed clears on an osc tick.
    // A reset shorter than one osc clock ends the hold at its release.
    always_comb begin
        next_warm     = 1'b1;
        next_armed    = armed;
        next_ret_lvl  = ret_lvl;
        next_ret_b1   = ret_b1;
        next_b1_stuck = b1_stuck;
        if (pon) begin
            next_armed    = 1'b0;
            next_ret_lvl  = 1'b0;
            next_ret_b1   = 1'b0;
            next_b1_stuck = 1'b0;
        end else if (!warm) begin
            if (osc_tick_i) begin
                next_armed = 1'b0;
            end
            next_b1_stuck = ret_b1;
        end else begin
            next_armed   = two_wire_mode_i &&
                           cfg_b.alt_sel[grpd_pkg::PB_TW_CLOCK];
            next_ret_lvl = two_wire_clk_out_i;
            next_ret_b1  = drv_b_o.oe[grpd_pkg::PB_LINE_ONE] &&
                           drv_b_o.out[grpd_pkg::PB_LINE_ONE];
            if (wr_en_i && wr_port_i == 2'h1 &&
                wr_cfg_i.dir_out[grpd_pkg::PB_LINE_ONE]) begin
                next_b1_stuck = 1'b0;
            end
        end
    end

    // Retained state: no reset, so a warm reset cannot erase it
    always_ff @(posedge clk_i) begin
        armed    <= next_armed;
        ret_lvl  <= next_ret_lvl;
        ret_b1   <= next_ret_b1;
        b1_stuck <= next_b1_stuck;
    end

    // Running flag: drops at once when any reset asserts
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            warm <= 1'b0;
        end else begin
            warm <= next_warm;
        end
    end

    // Pin drive: alternate defaults, plain GPIO otherwise
    always_comb begin
        drv_a_o.out = cfg_a.data_out;
        drv_a_o.oe  = cfg_a.dir_out & cfg_a.dig_en & ~cfg_a.alt_sel;
        drv_b_o.out = cfg_b.data_out;
        drv_b_o.oe  = cfg_b.dir_out & cfg_b.dig_en & ~cfg_b.alt_sel;
        drv_d_o.out = cfg_d.data_out;
        drv_d_o.oe  = cfg_d.dir_out & cfg_d.dig_en & ~cfg_d.alt_sel;
        drv_f_o.out = cfg_f.data_out;
        drv_f_o.oe  = cfg_f.dir_out & cfg_f.dig_en & ~cfg_f.alt_sel;
        if (cfg_a.alt_sel[grpd_pkg::PA_UART_TX]) begin
            drv_a_o.out[grpd_pkg::PA_UART_TX] = 1'b1;
            drv_a_o.oe[grpd_pkg::PA_UART_TX]  = 1'b1;
        end
        if (cfg_a.alt_sel[grpd_pkg::PA_SYNC_FSS]) begin
            drv_a_o.out[grpd_pkg::PA_SYNC_FSS] = 1'b1;
            drv_a_o.oe[grpd_pkg::PA_SYNC_FSS]  = 1'b1;
        end
        if (cfg_a.alt_sel[grpd_pkg::PA_SYNC_CLK]) begin
            drv_a_o.out[grpd_pkg::PA_SYNC_CLK] = 1'b0;
            drv_a_o.oe[grpd_pkg::PA_SYNC_CLK]  = 1'b1;
        end
        if (cfg_a.alt_sel[grpd_pkg::PA_SYNC_TX]) begin
            drv_a_o.out[grpd_pkg::PA_SYNC_TX] = 1'b0;
            drv_a_o.oe[grpd_pkg::PA_SYNC_TX]  = 1'b1;
        end
        if (hold_drv) begin
            drv_b_o.out[grpd_pkg::PB_TW_CLOCK] = ret_lvl;
            drv_b_o.oe[grpd_pkg::PB_TW_CLOCK]  = 1'b1;
        end
        if (b1_drv) begin
            drv_b_o.out[grpd_pkg::PB_LINE_ONE] = 1'b1;
            drv_b_o.oe[grpd_pkg::PB_LINE_ONE]  = 1'b1;
        end
    end

    // Status, CAN routing and NMI from reset-function pins
    always_comb begin
        alt_a_o    = cfg_a.alt_sel;
        alt_b_o    = cfg_b.alt_sel;
        alt_d_o    = cfg_d.alt_sel;
        alt_f_o    = cfg_f.alt_sel;
        fcode_d7_o = fc_d7;
        fcode_f0_o = fc_f0;
        can_receive_line_o = (fc_f0 == grpd_pkg::FCODE_CAN_RX) &&
                             sf[grpd_pkg::PF_LINE_ZERO];
        nmi_o = ((fc_d7 == grpd_pkg::FCODE_RESET) &&
                 sd[grpd_pkg::PD_LINE_SEVEN]) ||
                ((fc_f0 == grpd_pkg::FCODE_RESET) &&
                 sf[grpd_pkg::PF_LINE_ZERO]);
    end
endmodule
`default_nettype wire

// [grpd_pkg.sv]
// Package for the reset-time pin default block: constants and carriers
`default_nettype none
package grpd_pkg;
    // Pin indices within a port
    localparam int PA_UART_RX   = 0;
    localparam int PA_UART_TX   = 1;
    localparam int PA_SYNC_CLK  = 2;
    localparam int PA_SYNC_FSS  = 3;
    localparam int PA_SYNC_RX   = 4;
    localparam int PA_SYNC_TX   = 5;
    localparam int PB_LINE_ONE  = 1;
    localparam int PB_TW_CLOCK  = 2;
    localparam int PB_TW_DATA   = 3;
    localparam int PD_LINE_SEVEN = 7;
    localparam int PF_LINE_ZERO  = 0;
    // Reset values of the alternate function select bits
    localparam logic [7:0] ALT_SEL_A_RESET = 8'h3f;
    localparam logic [7:0] ALT_SEL_B_RESET = 8'h0c;
    localparam logic [7:0] ALT_SEL_D_RESET = 8'h00;
    localparam logic [7:0] ALT_SEL_F_RESET = 8'h00;
    localparam logic [7:0] DEN_RESET     = 8'h00;
    // Function code fields
    localparam int         FCODE_W       = 4;
    localparam logic [3:0] FCODE_RESET   = 4'h3;
    localparam logic [3:0] FCODE_CAN_RX  = 4'h3;
    localparam logic [3:0] FCODE_NONE    = 4'h0;

    // One port's software view
    typedef struct packed {
        logic [7:0] alt_sel;
        logic [7:0] dig_en;
        logic [7:0] dir_out;
        logic [7:0] data_out;
    } grpd_port_cfg_t;

    // Pin drive towards the board
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } grpd_pin_drv_t;
endpackage
`default_nettype wire

// [grpd_sync3.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module grpd_sync3 #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // Accept a change once stages two and three agree
    always_comb begin
        next_q = q_o;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_q[i] = s3[i];
            end
        end
    end

    // Register the stages
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1  <= '0;
            s2  <= '0;
            s3  <= '0;
            q_o <= '0;
        end else begin
            s1  <= d_i;
            s2  <= s1;
            s3  <= s2;
            q_o <= next_q;
        end
    end
endmodule
`default_nettype wire

// [grpd_gpio_props.sv]
// Checker of the pin default block's port behaviour
`timescale 1ns/100ps
`default_nettype none
module grpd_gpio_chk (
    input wire logic                     clk_i,
    input wire logic                     rst_b_i,
    input wire logic                     wr_en_i,
    input wire logic [1:0]               wr_port_i,
    input wire grpd_pkg::grpd_port_cfg_t wr_cfg_i,
    input wire logic                     commit_d7_i,
    input wire logic                     commit_f0_i,
    input wire logic                     fcode_wr_i,
    input wire logic [3:0]               fcode_f0_i,
    input wire logic [7:0]               pin_d_i,
    input wire logic [7:0]               pin_f_i,
    input wire grpd_pkg::grpd_pin_drv_t  drv_a_o,
    input wire grpd_pkg::grpd_pin_drv_t  drv_b_o,
    input wire logic [7:0]               alt_a_o,
    input wire logic [7:0]               alt_b_o,
    input wire logic [7:0]               alt_d_o,
    input wire logic [7:0]               alt_f_o,
    input wire logic [3:0]               fcode_d7_o,
    input wire logic [3:0]               fcode_f0_o,
    input wire logic                     can_receive_line_o,
    input wire logic                     nmi_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Pin held high long enough to cross the synchroniser
    sequence s_f0_held;
        (pin_f_i[0] && fcode_f0_o == 4'h3) [*8];
    endsequence
    sequence s_d7_held;
        (pin_d_i[7] && fcode_d7_o == 4'h3) [*8];
    endsequence
    // Reset values seen at the first edge after release; B1 at its written level after a port B write
    a_alt_reset: assert property (
        $rose(rst_b_i) |-> alt_a_o == 8'h3f && alt_b_o == 8'h0c)
        else $error("alt select reset value wrong");
    a_drive_reset: assert property (
        $rose(rst_b_i) |-> drv_a_o.oe == 8'h2e
        && (drv_a_o.out & 8'h2e) == 8'h0a && !drv_b_o.oe[3])
        else $error("port A reset drive wrong");
    a_b1_level: assert property (
        wr_en_i && wr_port_i == 2'h1 && wr_cfg_i.dir_out[1]
        && wr_cfg_i.dig_en[1] && !wr_cfg_i.alt_sel[1]
        |=> drv_b_o.oe[1] && drv_b_o.out[1] == $past(wr_cfg_i.data_out[1]))
        else $error("B1 not at programmed level");
    a_code_reset: assert property (
        $rose(rst_b_i) |-> fcode_d7_o == 4'h3 && fcode_f0_o == 4'h3)
        else $error("function code reset value wrong");
    // Protected bits and the F0 code move only under commit; port B alt writes, CAN routing and NMI
    a_d7_refused: assert property (
        wr_en_i && wr_port_i == 2'h2 && !commit_d7_i
        |=> $stable(alt_d_o[7])) else $error("D7 alt changed");
    a_f0_refused: assert property (
        wr_en_i && wr_port_i == 2'h3 && !commit_f0_i
        |=> $stable(alt_f_o[0])) else $error("F0 alt changed");
    a_code_refused: assert property (
        fcode_wr_i && !commit_f0_i |=> $stable(fcode_f0_o))
        else $error("F0 code changed without commit");
    a_code_taken: assert property (
        fcode_wr_i && commit_f0_i |=> fcode_f0_o == $past(fcode_f0_i))
        else $error("F0 code not taken");
    a_alt_write: assert property (
        wr_en_i && wr_port_i == 2'h1
        |=> alt_b_o == $past(wr_cfg_i.alt_sel))
        else $error("port B alt not written");
    a_can_route: assert property (s_f0_held |-> can_receive_line_o)
        else $error("CAN receive not routed");
    a_nmi_raise: assert property (s_d7_held |-> nmi_o)
        else $error("NMI not raised");
endmodule
bind grpd_gpio grpd_gpio_chk u_chk (.clk_i, .rst_b_i, .wr_en_i,
    .wr_port_i, .wr_cfg_i, .commit_d7_i, .commit_f0_i, .fcode_wr_i,
    .fcode_f0_i, .pin_d_i, .pin_f_i, .drv_a_o, .drv_b_o, .alt_a_o,
    .alt_b_o,
    .alt_d_o, .alt_f_o, .fcode_d7_o, .fcode_f0_o, .can_receive_line_o,
    .nmi_o);
`default_nettype wire

// [grpd_board.sv]
// Board model resolving the port D and F pins
`timescale 1ns/100ps
`default_nettype none
module grpd_board (
    input  wire logic                    clk_i,
    input  wire logic                    lvl_d7_i,
    input  wire logic                    lvl_f0_i,
    input  wire grpd_pkg::grpd_pin_drv_t drv_d_i,
    input  wire grpd_pkg::grpd_pin_drv_t drv_f_i,
    output logic      [7:0]              pin_d_o,
    output logic      [7:0]              pin_f_o
);
    logic [7:0] tog = 8'h55;
    // Floating lines toggle so no stale level survives
    always @(posedge clk_i) tog <= ~tog;
    // Device drive wins; D7 and F0 carry the board straps
    always_comb begin
        pin_d_o = (drv_d_i.out & drv_d_i.oe)
                | ({lvl_d7_i, tog[6:0]} & ~drv_d_i.oe);
        pin_f_o = (drv_f_i.out & drv_f_i.oe)
                | ({tog[7:1], lvl_f0_i} & ~drv_f_i.oe);
    end
endmodule
`default_nettype wire

// [tb_top.sv]
// Testbench of the pin default block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module tb_top;
    typedef struct packed {
        logic [1:0] port;
        logic       cd7;
        logic       cf0;
        logic [7:0] alt;
        logic [7:0] exp;
    } grpd_row_t;
    localparam grpd_row_t ROWS [6] = '{'{2'h0, 1'b0, 1'b0, 8'h00, 8'h00},
        '{2'h1, 1'b0, 1'b0, 8'h00, 8'h00}, '{2'h2, 1'b0, 1'b0, 8'hff, 8'h7f},
        '{2'h2, 1'b1, 1'b0, 8'hff, 8'hff}, '{2'h3, 1'b0, 1'b0, 8'hff, 8'hfe},
        '{2'h3, 1'b0, 1'b1, 8'h00, 8'h00}};
    logic clk_i = 1'b0, rst_b_i = 1'b0, por_i = 1'b1, osc_tick_i = 1'b0;
    logic two_wire_mode_i = 1'b1, two_wire_clk_out_i = 1'b1;
    logic wr_en_i = 1'b0, commit_d7_i = 1'b0, commit_f0_i = 1'b0;
    logic fcode_wr_i = 1'b0, lvl_d7 = 1'b0, lvl_f0 = 1'b0;
    logic [1:0] wr_port_i = 2'h0;
    logic [3:0] fcode_d7_i = 4'h0, fcode_f0_i = 4'h0;
    grpd_pkg::grpd_port_cfg_t wr_cfg_i = '0;
    wire logic [7:0] pin_d_i, pin_f_i, alt_a_o, alt_b_o, alt_d_o, alt_f_o;
    wire logic [3:0] fcode_d7_o, fcode_f0_o;
    wire logic can_receive_line_o, nmi_o;
    wire grpd_pkg::grpd_pin_drv_t drv_a_o, drv_b_o, drv_d_o, drv_f_o;
    wire logic [31:0] alts = {alt_f_o, alt_d_o, alt_b_o, alt_a_o};
    int n_fail = 0, total_checks = 0;
    grpd_gpio dut (.clk_i, .rst_b_i, .por_i, .osc_tick_i, .two_wire_mode_i,
        .two_wire_clk_out_i, .wr_en_i, .wr_port_i, .wr_cfg_i, .commit_d7_i,
        .commit_f0_i, .fcode_wr_i, .fcode_d7_i, .fcode_f0_i, .pin_d_i,
        .pin_f_i, .drv_a_o, .drv_b_o, .drv_d_o, .drv_f_o, .alt_a_o, .alt_b_o,
        .alt_d_o, .alt_f_o, .fcode_d7_o, .fcode_f0_o, .can_receive_line_o,
        .nmi_o);
    grpd_board u_board (.clk_i, .lvl_d7_i(lvl_d7), .lvl_f0_i(lvl_f0),
        .drv_d_i(drv_d_o), .drv_f_i(drv_f_o), .pin_d_o(pin_d_i),
        .pin_f_o(pin_f_i));
    // Clock at 125 MHz
    always #4 clk_i = ~clk_i;
    task automatic step(int n = 1);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(logic [1:0] p, grpd_pkg::grpd_port_cfg_t c);
        wr_port_i = p;
        wr_cfg_i = c;
        wr_en_i = 1'b1;
        step();
        wr_en_i = 1'b0;
    endtask
    task automatic fc(logic c7, logic cf, logic [3:0] d7, logic [3:0] f0);
        commit_d7_i = c7;
        commit_f0_i = cf;
        fcode_d7_i = d7;
        fcode_f0_i = f0;
        fcode_wr_i = 1'b1;
        step();
        fcode_wr_i = 1'b0;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #20000;
        n_fail++;
        print_verdict();
    end
    // Table of port writes, then reset and pin cases
    initial begin
        step(2);
        rst_b_i = 1'b1;
        step();
        foreach (ROWS[i]) begin
            commit_d7_i = ROWS[i].cd7;
            commit_f0_i = ROWS[i].cf0;
            wr(ROWS[i].port, {ROWS[i].alt, 24'h000000});
            `CHK(alts[ROWS[i].port*8 +: 8], ROWS[i].exp)
            step();
        end
        wr(2'h1, 32'h04020202);
        `CHK(drv_b_o.oe[1] & drv_b_o.out[1], 1'b1)
        step();
        por_i = 1'b0;
        rst_b_i = 1'b0;
        step();
        `CHK({alt_a_o, alt_b_o}, 16'h3f0c)
        `CHK({fcode_d7_o, fcode_f0_o}, 8'h33)
        `CHK(drv_a_o.oe, 8'h2e)
        `CHK(drv_a_o.out & 8'h2e, 8'h0a)
        `CHK(drv_b_o.oe[3], 1'b0)
        `CHK({drv_d_o.oe, drv_f_o.oe}, 16'h0000)
        `CHK({drv_b_o.oe[2:1], drv_b_o.out[2:1]}, 4'hf)
        osc_tick_i = 1'b1;
        step();
        osc_tick_i = 1'b0;
        `CHK(drv_b_o.oe[2:1], 2'b01)
        two_wire_mode_i = 1'b0;
        rst_b_i = 1'b1;
        step(2);
        `CHK(drv_b_o.oe[2:1], 2'b01)
        wr(2'h1, 32'h00020200);
        `CHK({drv_b_o.oe[1], drv_b_o.out[1]}, 2'b10)
        lvl_f0 = 1'b1;
        step(8);
        `CHK({can_receive_line_o, nmi_o}, 2'b11)
        fc(1'b0, 1'b0, 4'h0, 4'h0);
        `CHK(fcode_f0_o, 4'h3)
        step();
        fc(1'b0, 1'b1, 4'h0, 4'h0);
        `CHK({fcode_d7_o, fcode_f0_o}, 8'h30)
        lvl_d7 = 1'b1;
        step(8);
        `CHK({can_receive_line_o, nmi_o}, 2'b01)
        fc(1'b1, 1'b0, 4'h0, 4'h0);
        step(8);
        `CHK({fcode_d7_o, nmi_o}, 5'h00)
        print_verdict();
    end
endmodule
`default_nettype wire
